// ==== common/lpc_osc_if.sv ====
// Enable and ready handshake between the controller and an oscillator
// start-up timer. The controller drives en, the timer answers ready.
`timescale 1ns/100ps
interface lpc_osc_if;
  logic en;
  logic ready;
  modport ctl (output en, input ready);
  modport osc (input en, output ready);
endinterface // lpc_osc_if

// ==== common/lpc_pkg.sv ====
// Constants and types for the low power clock gating control block.
// Assumes a 25 MHz pclk and an APB register bus with 32-bit data.
package lpc_pkg;

  // Clock rate and oscillator start-up times
  localparam int unsigned PCLK_PERIOD_NS = 40;
  localparam int unsigned LSOSC_START_NS = 3000000;
  localparam int unsigned HSOSC_START_NS = 1000000;
  localparam int unsigned LSOSC_START_CYC =
    (LSOSC_START_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int unsigned HSOSC_START_CYC =
    (HSOSC_START_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

  // Register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] WAKE_OFS = 12'h008;

  // Control register fields
  localparam int unsigned CTRL_SEL_BIT = 0;
  localparam int unsigned CTRL_OFFDIS_BIT = 1;
  localparam int unsigned CTRL_PCLKOFF_BIT = 2;
  localparam int unsigned CTRL_GEAR_LSB = 4;
  localparam int unsigned GEAR_W = 3;
  localparam logic CTRL_SEL_RST = 1'h1;
  localparam logic CTRL_OFFDIS_RST = 1'h0;
  localparam logic CTRL_PCLKOFF_RST = 1'h0;
  localparam logic [2:0] CTRL_GEAR_RST = 3'h0;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_LSRDY_BIT = 4;
  localparam int unsigned STAT_HSRDY_BIT = 5;
  localparam int unsigned STAT_RTC_BIT = 6;
  localparam int unsigned STAT_DEEP_BIT = 7;

  // Wake cause fields
  localparam int unsigned WK_W = 5;
  localparam int unsigned WK_PORT = 0;
  localparam int unsigned WK_RTC = 1;
  localparam int unsigned WK_CT = 2;
  localparam int unsigned WK_WDT = 3;
  localparam int unsigned WK_PCLK = 4;

  // System clock source encoding
  localparam logic SYSCLK_LOW = 1'h0;
  localparam logic SYSCLK_HIGH = 1'h1;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HALT = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE = 4'h8
  } lpc_state_t;

endpackage

// ==== dv/lpc_clock_ctl_assertions.sv ====
// Port checker for the low power clock gating control block.
// Assumes a bind into lpc_clock_ctl, sampled on rising pclk.
`timescale 1ns/100ps
module lpc_clock_ctl_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // CPU side
  input wire logic cpu_slp_req,
  input wire logic cpu_halt_req,
  input wire logic cpu_wake,
  input wire logic cpu_stopped,
  // Wake sources
  input wire logic rtc_running,
  input wire logic port_irq,
  input wire logic pclk_periph_irq,
  // Gates
  input wire logic low_speed_oscillator_en,
  input wire logic high_speed_oscillator_en,
  input wire logic sysclk_sel,
  input wire logic cpu_core_clock_en,
  input wire logic pclk_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic run_slp;
  logic run_halt;
  logic osc_off;
  assign run_slp = !cpu_stopped && cpu_slp_req;
  assign run_halt = !cpu_stopped && cpu_halt_req && !cpu_slp_req;
  assign osc_off = !low_speed_oscillator_en && !high_speed_oscillator_en;
  chk_deep_osc_off: assert property (run_slp && !rtc_running |=>
    ##1 osc_off) else $error("deep sleep left an oscillator on");
  chk_deep_port_only: assert property (
    cpu_stopped && osc_off && !port_irq && !$past(port_irq) |=>
    cpu_stopped && osc_off)
    else $error("deep sleep left without port interrupt");
  chk_rtc_sleep_gates: assert property (run_slp && rtc_running |=>
    !pclk_en ##1 (low_speed_oscillator_en && !high_speed_oscillator_en))
    else $error("sleep with rtc gated wrong clocks");
  chk_halt_cpu_only: assert property (run_halt |=> cpu_stopped &&
    $stable(pclk_en) && $stable(high_speed_oscillator_en))
    else $error("halt changed more than the cpu clock");
  chk_stopped_no_clk: assert property (
    cpu_stopped |-> !cpu_core_clock_en)
    else $error("cpu clock enabled while stopped");
  chk_halt_wake_time: assert property (cpu_stopped && pclk_en &&
    (port_irq || pclk_periph_irq) |-> ##[1:2] cpu_wake)
    else $error("halt not left in time");
  chk_wake_osc_ready: assert property (cpu_wake |->
    !cpu_stopped && $past(cpu_stopped) && (sysclk_sel ?
    high_speed_oscillator_en : low_speed_oscillator_en))
    else $error("cpu released without its clock source");
  chk_apb_ready_one: assert property (psel && !penable |=>
    pready ##1 !pready) else $error("apb ready not one cycle");
endmodule // lpc_clock_ctl_chk

bind lpc_clock_ctl lpc_clock_ctl_chk lpc_clock_ctl_chk_i (.*);

// ==== dv/lpc_clock_ctl_tb_top.sv ====
// Self-checking bench for the low power clock gating control block.
// Assumes start-up counts of 4 cycles and a 25 MHz pclk.
`timescale 1ns/100ps
module lpc_clock_ctl_tb_top;
  import lpc_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [11:0] paddr = '0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slp_req;
  logic halt_req;
  logic cpu_wake;
  logic cpu_stopped;
  logic rtc_running = 1'h0;
  logic [4:0] irq = '0;
  logic lo_en;
  logic hi_en;
  logic sys_sel;
  logic cc_en;
  logic pclk_en;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int n_compared = 0;

  always #20 pclk = ~pclk;

  lpc_clock_ctl #(.LS_START_CYC(4), .HS_START_CYC(4)) lpc_clock_ctl_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_slp_req(slp_req), .cpu_halt_req(halt_req),
    .cpu_wake(cpu_wake), .cpu_stopped(cpu_stopped),
    .rtc_running(rtc_running), .port_irq(irq[WK_PORT]),
    .rtc_irq(irq[WK_RTC]), .ct_irq(irq[WK_CT]), .wdt_irq(irq[WK_WDT]),
    .pclk_periph_irq(irq[WK_PCLK]), .low_speed_oscillator_en(lo_en),
    .high_speed_oscillator_en(hi_en), .sysclk_sel(sys_sel),
    .cpu_core_clock_en(cc_en), .pclk_en(pclk_en));

  lpc_cpu_model lpc_cpu_model_i (.pclk(pclk), .cpu_core_clock_en(cc_en),
    .cpu_slp_req(slp_req), .cpu_halt_req(halt_req));

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %0t: got %h want %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic fire(input int b);
    @(posedge pclk);
    irq[b] <= 1'h1;
    @(posedge pclk);
    irq <= '0;
  endtask

  task automatic wake_in(input int n, input logic x);
    logic seen;
    seen = 1'h0;
    repeat (n) begin
      @(posedge pclk);
      if (cpu_wake === 1'h1) seen = 1'h1;
    end
    chk(seen, x);
  endtask

  task automatic t_regs;
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(q, 32'h1);
    apb(1'h0, 12'h00C, 32'h0);
    chk(q, 32'h0);
    chk(e, 1'h1);
    apb(1'h1, CTRL_OFS, 32'h2);
    repeat (8) @(posedge pclk);
    chk({sys_sel, lo_en, hi_en}, 3'h2);
    apb(1'h1, CTRL_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    $display("regs done");
  endtask

  task automatic t_gear;
    int t0;
    for (int g = 0; g < 8; g++) begin
      apb(1'h1, CTRL_OFS, 32'h1 | (g << CTRL_GEAR_LSB));
      repeat (16) @(posedge pclk);
      t0 = lpc_cpu_model_i.ticks;
      repeat (840) @(posedge pclk);
      chk(lpc_cpu_model_i.ticks - t0, 840 / (g + 1));
    end
    apb(1'h1, CTRL_OFS, 32'h1);
    $display("gear done");
  endtask

  task automatic t_halt;
    lpc_cpu_model_i.exec(1'h0);
    @(posedge pclk);
    chk({cpu_stopped, pclk_en, hi_en}, 3'h7);
    fire(WK_PCLK);
    wake_in(4, 1'h1);
    apb(1'h1, CTRL_OFS, 32'h5);
    lpc_cpu_model_i.exec(1'h0);
    fire(WK_PCLK);
    wake_in(6, 1'h0);
    fire(WK_RTC);
    wake_in(6, 1'h0);
    fire(WK_CT);
    wake_in(4, 1'h1);
    apb(1'h0, WAKE_OFS, 32'h0);
    chk(q, 32'h1 << WK_CT);
    lpc_cpu_model_i.exec(1'h0);
    fire(WK_WDT);
    wake_in(4, 1'h1);
    apb(1'h0, WAKE_OFS, 32'h0);
    chk(q, 32'h1 << WK_WDT);
    lpc_cpu_model_i.exec(1'h0);
    fire(WK_PORT);
    wake_in(4, 1'h1);
    apb(1'h1, CTRL_OFS, 32'h1);
    $display("halt done");
  endtask

  task automatic t_sleep(input logic rtc);
    rtc_running <= rtc;
    lpc_cpu_model_i.exec(1'h1);
    repeat (2) @(posedge pclk);
    chk({lo_en, hi_en, pclk_en}, {rtc, 2'h0});
    fire(WK_CT);
    wake_in(10, 1'h0);
    fire(rtc ? WK_RTC : WK_PCLK);
    wake_in(12, rtc);
    if (!rtc) fire(WK_PORT);
    if (!rtc) wake_in(12, 1'h1);
    chk(hi_en, 1'h1);
    $display("sleep done");
  endtask

  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 40);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
    t_regs();
    t_gear();
    t_halt();
    t_sleep(1'h1);
    t_sleep(1'h0);
    test_done();
  end
endmodule // lpc_clock_ctl_tb_top

// ==== dv/lpc_cpu_model.sv ====
// CPU core model: issues sleep and halt pulses, counts clock enables.
// Assumes the bench calls exec and reads ticks at rising pclk.
`timescale 1ns/100ps
module lpc_cpu_model (
  // Clock
  input wire logic pclk,
  // Gated clock enable
  input wire logic cpu_core_clock_en,
  // Instruction requests
  output logic cpu_slp_req,
  output logic cpu_halt_req
);
  int ticks = 0;
  initial begin
    cpu_slp_req = 1'h0;
    cpu_halt_req = 1'h0;
  end
  always @(posedge pclk) begin
    if (cpu_core_clock_en === 1'h1) ticks <= ticks + 1;
  end
  // One-cycle sleep or halt pulse
  task automatic exec(input logic slp);
    @(posedge pclk);
    cpu_slp_req <= slp;
    cpu_halt_req <= !slp;
    @(posedge pclk);
    cpu_slp_req <= 1'h0;
    cpu_halt_req <= 1'h0;
  endtask
endmodule // lpc_cpu_model

// ==== hdl/lpc_clock_ctl.sv ====
// Low power clock gating control: sleep, halt, clock source, gear,
// peripheral clock gate and wake-up selection behind an APB slave.
// Assumes sleep and halt requests are one-cycle pulses from the CPU and
// that interrupt inputs are synchronous levels to pclk.
//
// Contract
// - Sleep with real-time clock stopped halts CPU and both oscillators.
// - Deep sleep with both oscillators off wakes only on port interrupt.
// - Sleep with real-time clock running stops the fast oscillator and bus clock, not the slow one.
// - Sleep with real-time clock running wakes on port or RTC interrupt.
// - Halt gates only the CPU clock; peripherals keep running.
// - Halt ends on port or any still-clocked peripheral interrupt.
// - Software gear divides CPU clock by 1/1 down to 1/8.
// - Software picks system clock source and may stop the unused one.
// - Software gate stops the peripheral bus clock.
// - Gating the peripheral bus clock leaves other peripherals running.
// - Port interrupt wakes the CPU from every sleep and halt state.
// - RTC interrupt wakes the CPU whenever the RTC keeps running.
// - Halt with slow oscillator running allows clock timer or watchdog.
// - Peripheral bus interrupts wake from halt only if that clock runs.
`timescale 1ns/100ps
module lpc_clock_ctl
  import lpc_pkg::*;
#(
  parameter int unsigned LS_START_CYC = LSOSC_START_CYC,
  parameter int unsigned HS_START_CYC = HSOSC_START_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU core requests
  input wire logic cpu_slp_req,
  input wire logic cpu_halt_req,
  output logic cpu_wake,
  output logic cpu_stopped,
  // Real-time clock state
  input wire logic rtc_running,
  // Wake-up sources
  input wire logic port_irq,
  input wire logic rtc_irq,
  input wire logic ct_irq,
  input wire logic wdt_irq,
  input wire logic pclk_periph_irq,
  // Oscillator and clock gate controls
  output logic low_speed_oscillator_en,
  output logic high_speed_oscillator_en,
  output logic sysclk_sel,
  output logic cpu_core_clock_en,
  output logic pclk_en
);

  lpc_state_t state_r;
  lpc_state_t state_nxt;

  logic ctrl_sel_r;
  logic ctrl_offdis_r;
  logic ctrl_pclkoff_r;
  logic [GEAR_W-1:0] ctrl_gear_r;
  logic deep_r;
  logic [WK_W-1:0] wake_cause_r;
  logic [WK_W-1:0] wake_hit;
  logic ls_en_nxt;
  logic hs_en_nxt;
  logic sel_ready;
  logic gear_tick;
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_word;
  logic rd_err;

  lpc_osc_if ls_if ();
  lpc_osc_if hs_if ();

  // Oscillator start-up timers
  lpc_osc_start #(
    .START_CYC(LS_START_CYC)
  ) u_ls_start (
    .pclk(pclk),
    .presetn(presetn),
    .osc(ls_if.osc)
  );

  lpc_osc_start #(
    .START_CYC(HS_START_CYC)
  ) u_hs_start (
    .pclk(pclk),
    .presetn(presetn),
    .osc(hs_if.osc)
  );

  lpc_gear_div #(
    .W(GEAR_W)
  ) u_gear (
    .pclk(pclk),
    .presetn(presetn),
    .gear(ctrl_gear_r),
    .tick(gear_tick)
  );

  assign ls_if.en = low_speed_oscillator_en;
  assign hs_if.en = high_speed_oscillator_en;

  assign sel_ready = (ctrl_sel_r == SYSCLK_HIGH) ? hs_if.ready
                                                 : ls_if.ready;

  // APB phase decode
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;

  // Wake-up qualification per low power state
  always_comb begin
    wake_hit = '0;
    unique case (state_r)
      ST_SLEEP: begin
        wake_hit[WK_PORT] = port_irq;
        // RTC too when it keeps time
        wake_hit[WK_RTC] = rtc_irq && !deep_r;
      end
      ST_HALT: begin
        wake_hit[WK_PORT] = port_irq;
        wake_hit[WK_RTC] = rtc_irq && rtc_running;
        wake_hit[WK_CT] = ct_irq && low_speed_oscillator_en;
        wake_hit[WK_WDT] = wdt_irq && low_speed_oscillator_en;
        wake_hit[WK_PCLK] = pclk_periph_irq && pclk_en;
      end
      ST_RUN, ST_WAKE: begin
        wake_hit = '0;
      end
      default: begin
        wake_hit = '0;
      end
    endcase
  end

  // Power mode sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (cpu_slp_req) begin
          state_nxt = ST_SLEEP;
        end else if (cpu_halt_req) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        // Halt ends on a qualified interrupt
        if (|wake_hit) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_SLEEP: begin
        if (|wake_hit) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (sel_ready) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Deep sleep captured at sleep entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_r <= 1'h0;
    end else if (state_r == ST_RUN && cpu_slp_req) begin
      deep_r <= !rtc_running;
    end
  end

  // Oscillator demand
  always_comb begin
    if (state_r == ST_SLEEP) begin
      // Fast oscillator off, slow one kept for RTC
      hs_en_nxt = 1'h0;
      ls_en_nxt = !deep_r;
    end else begin
      hs_en_nxt = (ctrl_sel_r == SYSCLK_HIGH) || !ctrl_offdis_r;
      // Restarts the needed source on wake
      ls_en_nxt = (ctrl_sel_r == SYSCLK_LOW) || !ctrl_offdis_r ||
                  rtc_running;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_speed_oscillator_en <= 1'h1;
      high_speed_oscillator_en <= 1'h1;
    end else begin
      low_speed_oscillator_en <= ls_en_nxt;
      high_speed_oscillator_en <= hs_en_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_sel <= CTRL_SEL_RST;
    end else begin
      sysclk_sel <= ctrl_sel_r;
    end
  end

  // CPU clock gated in halt, sleep and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_core_clock_en <= 1'h0;
    end else begin
      cpu_core_clock_en <= (state_nxt == ST_RUN) && sel_ready &&
                           gear_tick;
    end
  end

  // Bus clock gate, off in sleep; other clocks unaffected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pclk_en <= 1'h0;
    end else begin
      pclk_en <= !ctrl_pclkoff_r && (state_nxt != ST_SLEEP) &&
                 sel_ready;
    end
  end

  // CPU status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_stopped <= 1'h0;
      cpu_wake <= 1'h0;
    end else begin
      cpu_stopped <= (state_nxt != ST_RUN);
      cpu_wake <= (state_r == ST_WAKE) && (state_nxt == ST_RUN);
    end
  end

  // Wake cause, loaded on each wake and cleared on each stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cause_r <= '0;
    end else if (|wake_hit) begin
      wake_cause_r <= wake_hit;
    end else if (state_r == ST_RUN && (cpu_slp_req || cpu_halt_req)) begin
      wake_cause_r <= '0;
    end
  end

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sel_r <= CTRL_SEL_RST;
      ctrl_offdis_r <= CTRL_OFFDIS_RST;
      ctrl_pclkoff_r <= CTRL_PCLKOFF_RST;
      ctrl_gear_r <= CTRL_GEAR_RST;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      ctrl_sel_r <= pwdata[CTRL_SEL_BIT];
      ctrl_offdis_r <= pwdata[CTRL_OFFDIS_BIT];
      // Only the bus clock gate, nothing else
      ctrl_pclkoff_r <= pwdata[CTRL_PCLKOFF_BIT];
      ctrl_gear_r <= pwdata[CTRL_GEAR_LSB +: GEAR_W];
    end
  end

  // Read mux
  always_comb begin
    rd_word = '0;
    rd_err = 1'h0;
    unique case (paddr)
      CTRL_OFS: begin
        rd_word[CTRL_SEL_BIT] = ctrl_sel_r;
        rd_word[CTRL_OFFDIS_BIT] = ctrl_offdis_r;
        rd_word[CTRL_PCLKOFF_BIT] = ctrl_pclkoff_r;
        rd_word[CTRL_GEAR_LSB +: GEAR_W] = ctrl_gear_r;
      end
      STAT_OFS: begin
        rd_word[STAT_STATE_LSB +: $bits(lpc_state_t)] = state_r;
        rd_word[STAT_LSRDY_BIT] = ls_if.ready;
        rd_word[STAT_HSRDY_BIT] = hs_if.ready;
        rd_word[STAT_RTC_BIT] = rtc_running;
        rd_word[STAT_DEEP_BIT] = deep_r;
      end
      WAKE_OFS: begin
        rd_word[WK_W-1:0] = wake_cause_r;
      end
      default: begin
        rd_err = 1'h1;
      end
    endcase
  end

  // APB answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= '0;
    end else if (apb_setup) begin
      pready <= 1'h1;
      pslverr <= rd_err;
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= '0;
    end
  end

endmodule // lpc_clock_ctl

// ==== hdl/lpc_gear_div.sv ====
// Clock gear: one tick every gear+1 cycles, so gear 0 gives 1/1 and
// gear 7 gives 1/8. A gear change takes effect on the next cycle, even mid-count.
`timescale 1ns/100ps
module lpc_gear_div #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Ratio and tick
  input wire logic [W-1:0] gear,
  output logic tick
);

  logic [W-1:0] cnt_r;

  // Divide counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick <= 1'h0;
    end else if (cnt_r >= gear) begin
      cnt_r <= '0;
      tick <= 1'h1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick <= 1'h0;
    end
  end

endmodule // lpc_gear_div

// ==== hdl/lpc_osc_start.sv ====
// Oscillator start-up timer: ready rises after en has stood START_CYC
// cycles. Assumes the oscillator settles within that time.
`timescale 1ns/100ps
module lpc_osc_start #(
  parameter int unsigned START_CYC = 4,
  parameter int unsigned CNT_W = $clog2(START_CYC + 1)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Handshake
  lpc_osc_if.osc osc
);

  logic [CNT_W-1:0] cnt_r;

  // Count settle time while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!osc.en) begin
      cnt_r <= '0;
    end else if (cnt_r != CNT_W'(START_CYC)) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Ready once settled, dropped at once on disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc.ready <= 1'h0;
    end else begin
      osc.ready <= osc.en && (cnt_r == CNT_W'(START_CYC));
    end
  end

endmodule // lpc_osc_start
